// ---- core/flic_pkg.sv ----
`default_nettype none
package flic_pkg;

   // Line and level counts
   localparam int NUM_LINES = 14;
   localparam int LOW_LINES = 6;
   localparam int NUM_LEVELS = 4;

   // Register addresses in the special function space
   localparam logic [7:0] ADDR_REQ_LOW  = 8'h9f;
   localparam logic [7:0] ADDR_EN_LOW   = 8'ha8;
   localparam logic [7:0] ADDR_REQ_HIGH = 8'ha9;
   localparam logic [7:0] ADDR_PLO_G0   = 8'hb8;
   localparam logic [7:0] ADDR_PHI_G0   = 8'hb9;
   localparam logic [7:0] ADDR_EN_HIGH  = 8'he8;
   localparam logic [7:0] ADDR_PLO_G1   = 8'hf8;
   localparam logic [7:0] ADDR_PHI_G1   = 8'hf9;

   // Field positions and reset values
   localparam int         GATE_BIT  = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // One access from the core to the register space
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       bit_mode;
      logic [2:0] bit_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } flic_sfr_t;

   // Winner of the priority resolution
   typedef struct packed {
      logic       valid;
      logic [3:0] line;
      logic [1:0] level;
   } flic_pick_t;

endpackage
`default_nettype wire

// ---- core/flic_pick.sv ----
`timescale 1ns/1ns
`default_nettype none
module flic_pick #(
   parameter int NUM_LINES = flic_pkg::NUM_LINES
) (
   input  wire logic [NUM_LINES-1:0] active_i,
   input  wire logic [NUM_LINES-1:0] prio_lo_i,
   input  wire logic [NUM_LINES-1:0] prio_hi_i,
   output flic_pkg::flic_pick_t      pick_o
);

   // Level of one line: upper bit from the high register
   function automatic logic [1:0] level_of(input logic hi, input logic lo);
      level_of = {hi, lo};
   endfunction

   // Scan upward; only a strictly higher level replaces the winner,
   // so among equal levels the lowest line stays
   always_comb
   begin
      pick_o = '0;
      for (int i = 0; i < NUM_LINES; i++)
      begin
         if (active_i[i] && (!pick_o.valid ||
             level_of(prio_hi_i[i], prio_lo_i[i]) > pick_o.level))
         begin
            pick_o.valid = 1'b1;
            pick_o.line  = 4'(i);
            pick_o.level = level_of(prio_hi_i[i], prio_lo_i[i]);
         end
      end
   end

endmodule
`default_nettype wire

// ---- core/flic_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module flic_ctrl #(
   parameter int NUM_LINES = flic_pkg::NUM_LINES,
   parameter int LOW_LINES = flic_pkg::LOW_LINES
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire flic_pkg::flic_sfr_t  sfr_i,
   output logic [7:0]                rdata_o,
   input  wire logic [NUM_LINES-1:0] src_req_i,
   input  wire logic                 ack_i,
   input  wire logic                 done_i,
   input  wire logic                 nmi_i,
   input  wire logic                 nmi_ack_i,
   output logic                      irq_o,
   output logic [3:0]                irq_line_o,
   output logic [1:0]                irq_level_o,
   output logic                      nmi_o
);

   localparam int HIGH_LINES = NUM_LINES - LOW_LINES;

   logic [NUM_LINES-1:0]  hw_r;
   logic [NUM_LINES-1:0]  sw_r;
   logic [NUM_LINES-1:0]  hw_nxt;
   logic [NUM_LINES-1:0]  sw_nxt;
   logic [NUM_LINES-1:0]  pending;
   logic [NUM_LINES-1:0]  active;
   logic [NUM_LINES-1:0]  en_r;
   logic [NUM_LINES-1:0]  plo_r;
   logic [NUM_LINES-1:0]  phi_r;
   logic                  gate_r;
   logic [3:0]            isr_r;
   logic [3:0]            isr_nxt;
   logic                  nmi_d_r;
   logic                  nmi_r;
   logic                  irq_r;
   logic                  irq_nxt;
   logic [3:0]            line_r;
   logic [1:0]            level_r;
   logic [7:0]            rdata_r;
   logic [7:0]            rdata_nxt;
   logic [2:0]            top;
   flic_pkg::flic_pick_t  pick;
   logic                  byte_wr;
   logic [7:0]            plo_g0_new;

   // Highest level in service: {valid, level}
   function automatic logic [2:0] top_of(input logic [3:0] isr);
      top_of = '0;
      for (int l = 0; l < flic_pkg::NUM_LEVELS; l++)
      begin
         if (isr[l])
         begin
            top_of = {1'b1, 2'(l)};
         end
      end
   endfunction

   // Byte write to one address
   function automatic logic wr_at(input flic_pkg::flic_sfr_t s,
                                  input logic [7:0] a);
      wr_at = s.wr && !s.bit_mode && (s.addr == a);
   endfunction

   // Bit or byte write merged into an old register value
   function automatic logic [7:0] merge(input flic_pkg::flic_sfr_t s,
                                        input logic [7:0] old);
      merge = old;
      if (s.bit_mode)
      begin
         merge[s.bit_sel] = s.wdata[0];
      end
      else
      begin
         merge = s.wdata;
      end
   endfunction

   assign byte_wr = sfr_i.wr && !sfr_i.bit_mode;
   // Group 0 has six lines; the merge works on a padded byte
   assign plo_g0_new = merge(sfr_i, {2'b00, plo_r[LOW_LINES-1:0]});
   assign pending = hw_r | sw_r;
   // Enable masks the interrupt only, never the request bit
   assign active  = pending & en_r & {NUM_LINES{gate_r}};
   assign top     = top_of(isr_r);

   // Priority resolution across enabled pending lines
   flic_pick #(
      .NUM_LINES (NUM_LINES)
   ) u_pick (
      .active_i  (active),
      .prio_lo_i (plo_r),
      .prio_hi_i (phi_r),
      .pick_o    (pick)
   );

   // Next request state: acknowledge clears, new requests win
   always_comb
   begin
      hw_nxt = hw_r;
      sw_nxt = sw_r;
      if (ack_i && irq_r)
      begin
         hw_nxt[line_r] = 1'b0;
         sw_nxt[line_r] = 1'b0;
      end
      if (wr_at(sfr_i, flic_pkg::ADDR_REQ_LOW))
      begin
         // Writes touch only the software bits
         sw_nxt[LOW_LINES-1:0] = sfr_i.wdata[LOW_LINES-1:0];
      end
      if (wr_at(sfr_i, flic_pkg::ADDR_REQ_HIGH))
      begin
         sw_nxt[NUM_LINES-1:LOW_LINES] =
            sfr_i.wdata[HIGH_LINES-1:0];
      end
      hw_nxt = hw_nxt | src_req_i;
   end

   // Request storage
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hw_r <= '0;
         sw_r <= '0;
      end
      else
      begin
         hw_r <= hw_nxt;
         sw_r <= sw_nxt;
      end
   end

   // Enable registers and global gate, byte access
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         en_r   <= '0;
         gate_r <= 1'b0;
      end
      else
      begin
         if (wr_at(sfr_i, flic_pkg::ADDR_EN_LOW))
         begin
            en_r[LOW_LINES-1:0] <= sfr_i.wdata[LOW_LINES-1:0];
            gate_r <= sfr_i.wdata[flic_pkg::GATE_BIT];
         end
         if (wr_at(sfr_i, flic_pkg::ADDR_EN_HIGH))
         begin
            en_r[NUM_LINES-1:LOW_LINES] <= sfr_i.wdata[HIGH_LINES-1:0];
         end
      end
   end

   // Low priority bits: bit or byte writes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         plo_r <= '0;
      end
      else if (sfr_i.wr && sfr_i.addr == flic_pkg::ADDR_PLO_G0)
      begin
         plo_r[LOW_LINES-1:0] <= plo_g0_new[LOW_LINES-1:0];
      end
      else if (sfr_i.wr && sfr_i.addr == flic_pkg::ADDR_PLO_G1)
      begin
         plo_r[NUM_LINES-1:LOW_LINES] <=
            merge(sfr_i, plo_r[NUM_LINES-1:LOW_LINES]);
      end
   end

   // High priority bits: whole bytes only, bit writes ignored
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phi_r <= '0;
      end
      else if (wr_at(sfr_i, flic_pkg::ADDR_PHI_G0))
      begin
         phi_r[LOW_LINES-1:0] <= sfr_i.wdata[LOW_LINES-1:0];
      end
      else if (wr_at(sfr_i, flic_pkg::ADDR_PHI_G1))
      begin
         phi_r[NUM_LINES-1:LOW_LINES] <= sfr_i.wdata[HIGH_LINES-1:0];
      end
   end

   // In-service levels: done ends the top one, ack opens a new one
   always_comb
   begin
      isr_nxt = isr_r;
      if (done_i && top[2])
      begin
         isr_nxt[top[1:0]] = 1'b0;
      end
      if (ack_i && irq_r)
      begin
         isr_nxt[level_r] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         isr_r <= '0;
      end
      else
      begin
         isr_r <= isr_nxt;
      end
   end

   // Offer only a level above every service in progress; no offer from one cycle after NMI is latched until it clears
   always_comb
   begin
      irq_nxt = pick.valid && gate_r && !nmi_r && !(ack_i && irq_r);
      if (top[2] && pick.level <= top[1:0])
      begin
         irq_nxt = 1'b0;
      end
   end

   // Request to the core
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         irq_r   <= 1'b0;
         line_r  <= '0;
         level_r <= '0;
      end
      else
      begin
         irq_r   <= irq_nxt;
         line_r  <= pick.line;
         level_r <= pick.level;
      end
   end

   // Non-maskable request: edge latched, cleared by its acknowledge
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         nmi_d_r <= 1'b0;
         nmi_r   <= 1'b0;
      end
      else
      begin
         nmi_d_r <= nmi_i;
         if (nmi_i && !nmi_d_r)
         begin
            nmi_r <= 1'b1;
         end
         else if (nmi_ack_i)
         begin
            nmi_r <= 1'b0;
         end
      end
   end

   // Read mux; unmapped addresses and unused bits read zero
   always_comb
   begin
      rdata_nxt = flic_pkg::READ_ZERO;
      if (sfr_i.addr == flic_pkg::ADDR_REQ_LOW)
      begin
         rdata_nxt[LOW_LINES-1:0] = pending[LOW_LINES-1:0];
      end
      else if (sfr_i.addr == flic_pkg::ADDR_REQ_HIGH)
      begin
         rdata_nxt = pending[NUM_LINES-1:LOW_LINES];
      end
      else if (sfr_i.addr == flic_pkg::ADDR_EN_LOW)
      begin
         rdata_nxt[LOW_LINES-1:0] = en_r[LOW_LINES-1:0];
         rdata_nxt[flic_pkg::GATE_BIT] = gate_r;
      end
      else if (sfr_i.addr == flic_pkg::ADDR_EN_HIGH)
      begin
         rdata_nxt = en_r[NUM_LINES-1:LOW_LINES];
      end
      else if (sfr_i.addr == flic_pkg::ADDR_PLO_G0)
      begin
         rdata_nxt[LOW_LINES-1:0] = plo_r[LOW_LINES-1:0];
      end
      else if (sfr_i.addr == flic_pkg::ADDR_PHI_G0)
      begin
         rdata_nxt[LOW_LINES-1:0] = phi_r[LOW_LINES-1:0];
      end
      else if (sfr_i.addr == flic_pkg::ADDR_PLO_G1)
      begin
         rdata_nxt = plo_r[NUM_LINES-1:LOW_LINES];
      end
      else if (sfr_i.addr == flic_pkg::ADDR_PHI_G1)
      begin
         rdata_nxt = phi_r[NUM_LINES-1:LOW_LINES];
      end
   end

   // Read data holds until the next read
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_r <= flic_pkg::REG_RESET;
      end
      else if (sfr_i.rd)
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata_o     = rdata_r;
   assign irq_o       = irq_r;
   assign irq_line_o  = line_r;
   assign irq_level_o = level_r;
   assign nmi_o       = nmi_r;

   // Checks on the design's own outputs and state
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_req_read_low: assert property (
      sfr_i.rd && sfr_i.addr == flic_pkg::ADDR_REQ_LOW |=>
         rdata_o == {2'b00, $past(pending[LOW_LINES-1:0])})
      else $error("low request read wrong");

   a_req_read_high: assert property (
      sfr_i.rd && sfr_i.addr == flic_pkg::ADDR_REQ_HIGH |=>
         rdata_o == $past(pending[NUM_LINES-1:LOW_LINES]))
      else $error("high request read wrong");

   a_sw_set_line: assert property (
      byte_wr && sfr_i.addr == flic_pkg::ADDR_REQ_HIGH &&
      sfr_i.wdata[0] |=> pending[LOW_LINES] ##1 1'b1)
      else $error("software request not raised");

   a_sw_clear_line: assert property (
      byte_wr && sfr_i.addr == flic_pkg::ADDR_REQ_LOW && !sfr_i.wdata[0] &&
      !src_req_i[0] && !hw_r[0] |=> !pending[0])
      else $error("clear did not remove request");

   a_src_kept: assert property (
      byte_wr && sfr_i.addr == flic_pkg::ADDR_REQ_LOW && !sfr_i.wdata[2] &&
      src_req_i[2] |=> pending[2])
      else $error("source request lost by clear");

   a_ack_clears: assert property (
      ack_i && irq_o && !src_req_i[irq_line_o] && !sfr_i.wr |=>
         !pending[$past(irq_line_o)])
      else $error("acknowledge did not clear line");

   a_gate_blocks: assert property (
      !gate_r [*2] |=> !irq_o)
      else $error("interrupt while globally disabled");

   a_enable_needed: assert property (
      irq_o |-> $past(en_r[pick.line] && pending[pick.line]))
      else $error("interrupt from disabled line");

   a_level_above: assert property (
      irq_o && $past(top[2]) |-> irq_level_o > $past(top[1:0]))
      else $error("interrupt not above service level");

   a_nmi_wins: assert property (
      nmi_o |=> !irq_o)
      else $error("maskable interrupt beside NMI");

   a_phi_byte_only: assert property (
      sfr_i.wr && sfr_i.bit_mode |=> $stable(phi_r))
      else $error("bit write reached high priority");

   c_ack_taken:  cover property (irq_o && ack_i ##[1:20] done_i);
   c_preempt:    cover property (top[2] && irq_o && irq_level_o > top[1:0]);
   c_nmi_seen:   cover property (nmi_o ##[1:10] nmi_ack_i);
   c_sw_request: cover property (sw_r != '0 ##[1:5] irq_o);

endmodule
`default_nettype wire

// ---- verification/flic_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module flic_core_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       irq_i,
   input  wire logic [3:0] irq_line_i,
   input  wire logic       take_i,
   input  wire logic [1:0] delay_i,
   output logic            ack_o,
   output logic [3:0]      line_o
);
   logic [1:0] wait_r;

   // Acknowledge an offered interrupt after a chosen wait, one cycle only
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ack_o  <= 1'b0;
         line_o <= 4'h0;
         wait_r <= 2'h0;
      end
      else if (ack_o || !irq_i || !take_i)
      begin
         ack_o  <= 1'b0;
         wait_r <= 2'h0;
      end
      else if (wait_r == delay_i)
      begin
         ack_o  <= 1'b1;
         line_o <= irq_line_i;
      end
      else
         wait_r <= wait_r + 2'h1;
   end
endmodule
`default_nettype wire

// ---- verification/test_fourteen_line_irq_controller.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_fourteen_line_irq_controller;
   logic                clk_i;
   logic                rst_i;
   flic_pkg::flic_sfr_t sfr;
   logic [7:0]          rdata;
   logic [13:0]         src;
   logic                ack_i;
   logic                done;
   logic                nmi;
   logic                nmi_ack;
   logic                irq_o;
   logic [3:0]          irq_line_o;
   logic [1:0]          irq_level_o;
   logic                nmi_o;
   logic                take;
   logic [1:0]          dly;
   logic [3:0]          acked_line;
   int                  n_mismatch;
   int                  num_checks;
   int                  cycles = 0;
   int                  i;
   // Rows: address, write data, expected read back
   logic [23:0] rows [17] = '{24'ha8bfbf, 24'he8ffff, 24'hb83f3f,
      24'hb93f3f, 24'hf8ffff, 24'hf9ffff, 24'h9f1515, 24'h9f0000,
      24'ha9a5a5, 24'ha90000, 24'h805500, 24'ha80000, 24'he80000,
      24'hb80000, 24'hb90000, 24'hf80000, 24'hf90000};

   // Design under test
   flic_ctrl i_flic_ctrl (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .sfr_i       (sfr),
      .rdata_o     (rdata),
      .src_req_i   (src),
      .ack_i       (ack_i),
      .done_i      (done),
      .nmi_i       (nmi),
      .nmi_ack_i   (nmi_ack),
      .irq_o       (irq_o),
      .irq_line_o  (irq_line_o),
      .irq_level_o (irq_level_o),
      .nmi_o       (nmi_o)
   );

   // Core side that acknowledges offered interrupts
   flic_core_model i_flic_core_model (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .irq_i      (irq_o),
      .irq_line_i (irq_line_o),
      .take_i     (take),
      .delay_i    (dly),
      .ack_o      (ack_i),
      .line_o     (acked_line)
   );

   // Clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog on the whole run
   always @(posedge clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch %0t run timed out", $time);
         finish_test();
      end
   end

   // Compare one value
   task automatic check(input logic [7:0] got, input logic [7:0] exp,
                        input string msg);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // One register access: strobe for one edge, then idle
   task automatic access(input logic w, input logic bm, input logic [2:0] bs,
                         input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr <= '{wr: w, rd: !w, bit_mode: bm, bit_sel: bs, addr: a, wdata: d};
      @(posedge clk_i);
      sfr <= '0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, 1'b0, 3'h0, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input string msg);
      access(1'b0, 1'b0, 3'h0, a, 8'h00);
      check(rdata, exp, msg);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic pulse_done();
      @(posedge clk_i);
      done <= 1'b1;
      @(posedge clk_i);
      done <= 1'b0;
      #1;
   endtask

   initial
   begin
      n_mismatch = 0;
      num_checks = 0;
      sfr = '0;
      src = '0;
      done = 1'b0;
      nmi = 1'b0;
      nmi_ack = 1'b0;
      take = 1'b0;
      dly = 2'h0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check(irq_o, 8'h00, "irq after reset");
      rd(flic_pkg::ADDR_REQ_LOW, 8'h00, "low request after reset");
      rd(flic_pkg::ADDR_REQ_HIGH, 8'h00, "high request after reset");
      $display("test reset done");

      // Table of writes and read backs; unused bits written zero, except at the unmapped address
      for (i = 0; i < 17; i++)
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0], "row read back");
      end
      $display("test table done");

      // Masked source still sets its bit; enable lets it through
      wr(flic_pkg::ADDR_EN_LOW, 8'h80);
      @(posedge clk_i);
      src <= 14'h0008;
      tick(3);
      check(irq_o, 8'h00, "masked line offered");
      rd(flic_pkg::ADDR_REQ_LOW, 8'h08, "masked request bit");
      wr(flic_pkg::ADDR_EN_LOW, 8'h88);
      tick(1);
      check(irq_o, 8'h01, "enabled line not offered");
      check(irq_line_o, 8'h03, "wrong line offered");
      wr(flic_pkg::ADDR_EN_LOW, 8'h08);
      tick(1);
      check(irq_o, 8'h00, "offered with gate closed");
      wr(flic_pkg::ADDR_EN_LOW, 8'h88);
      wr(flic_pkg::ADDR_REQ_LOW, 8'h00);
      rd(flic_pkg::ADDR_REQ_LOW, 8'h08, "source lost by clear");
      @(posedge clk_i);
      src <= '0;
      take <= 1'b1;
      tick(6);
      take <= 1'b0;
      check(acked_line, 8'h03, "acknowledged line");
      rd(flic_pkg::ADDR_REQ_LOW, 8'h00, "ack left request");
      pulse_done();
      wr(flic_pkg::ADDR_REQ_LOW, 8'h02);
      rd(flic_pkg::ADDR_REQ_LOW, 8'h02, "software set");
      wr(flic_pkg::ADDR_REQ_LOW, 8'h00);
      rd(flic_pkg::ADDR_REQ_LOW, 8'h00, "software clear");
      $display("test request done");

      // Lines 1, 2 at level 1, line 7 at level 3
      wr(flic_pkg::ADDR_EN_LOW, 8'h86);
      wr(flic_pkg::ADDR_EN_HIGH, 8'h02);
      wr(flic_pkg::ADDR_PLO_G0, 8'h06);
      wr(flic_pkg::ADDR_PHI_G0, 8'h00);
      wr(flic_pkg::ADDR_PLO_G1, 8'h02);
      wr(flic_pkg::ADDR_PHI_G1, 8'h02);
      wr(flic_pkg::ADDR_REQ_LOW, 8'h06);
      tick(1);
      check(irq_line_o, 8'h01, "lowest line first");
      check(irq_level_o, 8'h01, "level of line 1");
      @(posedge clk_i);
      take <= 1'b1;
      tick(6);
      take <= 1'b0;
      check(acked_line, 8'h01, "served line");
      check(irq_o, 8'h00, "equal level offered");
      wr(flic_pkg::ADDR_REQ_HIGH, 8'h02);
      tick(1);
      check(irq_o, 8'h01, "higher level held back");
      check(irq_line_o, 8'h07, "pre-empting line");
      check(irq_level_o, 8'h03, "pre-empting level");
      pulse_done();
      wr(flic_pkg::ADDR_REQ_HIGH, 8'h00);
      tick(1);
      check(irq_o, 8'h01, "waiting line after done");
      check(irq_line_o, 8'h02, "waiting line number");
      $display("test priority done");

      // Non-maskable request hides the maskable one
      @(posedge clk_i);
      nmi <= 1'b1;
      tick(2);
      check(nmi_o, 8'h01, "nmi not raised");
      check(irq_o, 8'h00, "irq beside nmi");
      @(posedge clk_i);
      nmi_ack <= 1'b1;
      @(posedge clk_i);
      nmi_ack <= 1'b0;
      nmi <= 1'b0;
      tick(1);
      check(nmi_o, 8'h00, "nmi not cleared");
      $display("test nmi done");

      // Bit writes reach only the low priority registers
      access(1'b1, 1'b1, 3'h0, flic_pkg::ADDR_PHI_G0, 8'h01);
      rd(flic_pkg::ADDR_PHI_G0, 8'h00, "bit write to high prio");
      access(1'b1, 1'b1, 3'h0, flic_pkg::ADDR_PLO_G0, 8'h01);
      rd(flic_pkg::ADDR_PLO_G0, 8'h07, "bit write to low prio");
      $display("test bit access done");

      // Reset in mid run with a request pending
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check(irq_o, 8'h00, "irq after mid reset");
      rd(flic_pkg::ADDR_REQ_LOW, 8'h00, "request after mid reset");
      $display("test mid reset done");
      finish_test();
   end
endmodule
`default_nettype wire
